// ### cbs_capture_b.v
/*
  Capture register B source selection with its own free-running counter and APB slave.
  Assumes a single 40 MHz clock, synchronous reset, and asynchronous trigger and pin inputs.
*/
`timescale 1ns/10ps
`include "cbs_map.vh"
module cbs_capture_b (
  input wire mclk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [3:0] external_trigger_i,
  input wire [3:0] timer_io_pin_a_i,
  input wire [3:0] timer_io_pin_b_i,
  output wire [31:0] capture_register_b_o,
  output wire capture_pulse_o
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function trig_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `CBS_SEL_OFF: trig_hit = 1'b0;
        `CBS_SEL_LOW: trig_hit = rise;
        `CBS_SEL_HIGH: trig_hit = fall;
        `CBS_SEL_ANY: trig_hit = rise | fall;
        default: trig_hit = 1'b0;
      endcase
    end
  endfunction

  function pin_hit;
    input [1:0] sel;
    input rise;
    input qual;
    begin
      case (sel)
        `CBS_SEL_OFF: pin_hit = 1'b0;
        `CBS_SEL_LOW: pin_hit = rise & ~qual;
        `CBS_SEL_HIGH: pin_hit = rise & qual;
        `CBS_SEL_ANY: pin_hit = rise;
        default: pin_hit = 1'b0;
      endcase
    end
  endfunction

  function [31:0] byte_merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] strb;
    integer k;
    begin
      byte_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          byte_merge[k*8 +: 8] = wdata[k*8 +: 8];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  wire [11:0] sync_level;
  wire [11:0] sync_rise;
  wire [11:0] sync_fall;

  cbs_sync_edge #(
    .W(12)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({timer_io_pin_b_i, timer_io_pin_a_i, external_trigger_i}),
    .level_o(sync_level),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  wire [3:0] trig_rise = sync_rise[3:0];
  wire [3:0] trig_fall = sync_fall[3:0];
  wire [3:0] pin_a_rise = sync_rise[7:4];
  wire [3:0] pin_b_level = sync_level[11:8];

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [31:0] src_sel_q;
  reg [31:0] capt_b_q;
  reg [31:0] counter_q;
  reg capt_seen_q;
  reg capt_pulse_q;
  reg [31:0] prdata_q;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------

  wire apb_setup = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire wr_en = apb_access & pwrite_i;
  wire hit_sel = (paddr_i == `CBS_OFF_SRC_SEL);
  wire hit_capt = (paddr_i == `CBS_OFF_CAPT_B);
  wire hit_cnt = (paddr_i == `CBS_OFF_COUNTER);
  wire hit_stat = (paddr_i == `CBS_OFF_STATUS);
  wire mapped = hit_sel | hit_capt | hit_cnt | hit_stat;

  // --------------------------------------------------------------------------
  // Source evaluation
  // --------------------------------------------------------------------------
  // Pin pair n: A rising qualified by B, reusing the pin channel index for both.
  reg [3:0] src_trig;
  reg [3:0] src_pin;
  integer i;
  always @*
  begin
    src_trig = 4'h0;
    src_pin = 4'h0;
    for (i = 0; i < `CBS_NUM_SRC; i = i + 1)
    begin
      src_trig[i] = trig_hit(src_sel_q[`CBS_TRIG_LSB + 2*i +: 2],
        trig_rise[i], trig_fall[i]);
      src_pin[i] = pin_hit(src_sel_q[`CBS_PIN_LSB + 2*i +: 2],
        pin_a_rise[i], pin_b_level[i]);
    end
  end

  // --------------------------------------------------------------------------
  // Capture strobe
  // --------------------------------------------------------------------------
  wire trig_any = |src_trig;
  wire pin_any = |src_pin;
  wire stat_clear = wr_en & hit_stat & pstrb_i[0] & pwdata_i[`CBS_STAT_CAPT_BIT];

  // All sources collapse into one strobe, so coincident events capture once.
  wire capt_now = trig_any | pin_any;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  reg [31:0] src_sel_d;
  reg [31:0] capt_b_d;
  reg [31:0] counter_d;
  reg capt_seen_d;
  reg capt_pulse_d;
  reg [31:0] prdata_d;

  // The counter wraps freely, so software must work with differences of readings.
  always @*
  begin
    counter_d = counter_q + 32'h00000001;
  end

  // The stored value is the counter of the cycle in which the strobe is seen.
  always @*
  begin
    capt_b_d = capt_b_q;
    if (capt_now)
    begin
      capt_b_d = counter_q;
    end
  end

  always @*
  begin
    capt_pulse_d = 1'b0;
    if (capt_now)
    begin
      capt_pulse_d = 1'b1;
    end
  end

  // Bytes without a strobe keep their value; the unused upper half reads as zero.
  always @*
  begin
    src_sel_d = src_sel_q;
    if (wr_en && hit_sel)
    begin
      src_sel_d = byte_merge(src_sel_q, pwdata_i, pstrb_i) & `CBS_SRC_SEL_MASK;
    end
  end

  // A new capture in the clearing cycle wins over the software clear.
  always @*
  begin
    capt_seen_d = capt_seen_q;
    if (capt_now)
    begin
      capt_seen_d = 1'b1;
    end
    else if (stat_clear)
    begin
      capt_seen_d = 1'b0;
    end
  end

  // Read data is taken in the setup cycle, so the access phase never waits.
  always @*
  begin
    prdata_d = prdata_q;
    if (apb_setup && !pwrite_i)
    begin
      case (paddr_i)
        `CBS_OFF_SRC_SEL: prdata_d = src_sel_q;
        `CBS_OFF_CAPT_B: prdata_d = capt_b_q;
        `CBS_OFF_COUNTER: prdata_d = counter_q;
        `CBS_OFF_STATUS: prdata_d = {31'h00000000, capt_seen_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  // Reset is synchronous, so the clock must keep running while it is held.
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      src_sel_q <= `CBS_SRC_SEL_RST;
    end
    else
    begin
      src_sel_q <= src_sel_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      capt_b_q <= 32'h00000000;
    end
    else
    begin
      capt_b_q <= capt_b_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      counter_q <= 32'h00000000;
    end
    else
    begin
      counter_q <= counter_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      capt_seen_q <= 1'b0;
    end
    else
    begin
      capt_seen_q <= capt_seen_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      capt_pulse_q <= 1'b0;
    end
    else
    begin
      capt_pulse_q <= capt_pulse_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prdata_q <= 32'h00000000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every access completes in its first access cycle, so ready is tied high.
  assign pready_o = 1'b1;
  // Unmapped offsets still complete, with an error flag, so software never hangs.
  assign pslverr_o = apb_access & ~mapped;
  assign prdata_o = prdata_q;
  assign capture_register_b_o = capt_b_q;
  assign capture_pulse_o = capt_pulse_q;
endmodule // cbs_capture_b

// ### cbs_map.vh
/*
  Constants for the capture B source select block: register offsets, field positions,
  reset values and edge-select encodings.
  Assumes inclusion by the design files of the block only; holds definitions alone.
*/
// What this block does
// - Trigger field 00: no capture into register B from that trigger input.
// - Trigger field 01: capture counter on each rising edge of the trigger.
// - Trigger field 10: capture counter on each falling edge of the trigger.
// - Trigger field 11: capture counter on both edges of the trigger.
// - Fields at bits 3:2, 5:4, 7:6 serve three further trigger inputs identically.
// - Pin field 00: rising edge of pin A causes no capture.
// - Pin field 01: capture on pin A rising edge while pin B is low.
// - Pin field 10: capture on pin A rising edge while pin B is high.
// - Pin field 11: capture on every pin A rising edge regardless of pin B.
// - Fields at bits 11:10, 13:12, 15:14 serve three further pin pairs identically.
`ifndef CBS_MAP_VH
`define CBS_MAP_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CBS_OFF_SRC_SEL 12'h000
`define CBS_OFF_CAPT_B 12'h004
`define CBS_OFF_COUNTER 12'h008
`define CBS_OFF_STATUS 12'h00C
`define CBS_ADDR_W 12
`define CBS_SRC_SEL_RST 32'h00000000
`define CBS_SRC_SEL_MASK 32'h0000FFFF

// ----------------------------------------------------------------------------
// Fields and encodings
// ----------------------------------------------------------------------------
`define CBS_TRIG_LSB 0
`define CBS_PIN_LSB 8
`define CBS_NUM_SRC 4
`define CBS_SEL_OFF 2'h0
`define CBS_SEL_LOW 2'h1
`define CBS_SEL_HIGH 2'h2
`define CBS_SEL_ANY 2'h3
`define CBS_STAT_CAPT_BIT 0

`endif

// ### cbs_sync_edge.v
/*
  Two-flop synchroniser with a third stage for edge detection, one per input bit.
  Assumes the inputs are asynchronous levels and rst_i is synchronous active high.
*/
`timescale 1ns/10ps
module cbs_sync_edge #(
  parameter W = 4
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;

  // The first stage feeds only the second, so no logic sees a metastable value.
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      prev_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule // cbs_sync_edge

// ### cbs_props.sv
/* Checker for the capture B source block, watching its top-level ports only.
   Assumes the bench writes whole words to the select register. */
`timescale 1ns/10ps
module cbs_props (
  input wire mclk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [3:0] external_trigger_i,
  input wire [3:0] timer_io_pin_a_i,
  input wire [3:0] timer_io_pin_b_i,
  input wire [31:0] capture_register_b_o,
  input wire capture_pulse_o
);
  logic [15:0] sel_q;
  wire acc = psel_i && penable_i;
  always_ff @(posedge mclk_i)
    if (rst_i)
      sel_q <= 16'h0000;
    else if (acc && pwrite_i && paddr_i == 12'h000)
      sel_q <= pwdata_i[15:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  bus_ready_a: assert property (pready_o) else $error("pready low");
  err_scope_a: assert property (pslverr_o |-> acc) else $error("pslverr outside access");
  sel_upper_a: assert property (acc && !pwrite_i && paddr_i == 12'h000
    |-> prdata_o[31:16] == 16'h0000) else $error("select upper bits set");
  capt_pulse_a: assert property (!$stable(capture_register_b_o) |-> capture_pulse_o)
    else $error("capture without pulse");
  trig_off_a: assert property ($past(sel_q) == 16'h0000 |-> !capture_pulse_o)
    else $error("capture while all sources off");
  trig_rise_a: assert property ($rose(external_trigger_i[0]) && sel_q[1:0] == 2'h1
    |-> ##[1:6] capture_pulse_o) else $error("no capture on trigger rise");
  trig_fall_a: assert property ($fell(external_trigger_i[1]) && sel_q[3:2] == 2'h2
    |-> ##[1:6] capture_pulse_o) else $error("no capture on trigger fall");
  trig_both_a: assert property (!$stable(external_trigger_i[3]) && sel_q[7:6] == 2'h3
    |-> ##[1:6] capture_pulse_o) else $error("no capture on trigger edge");
  pin_low_a: assert property ($rose(timer_io_pin_a_i[0]) && !timer_io_pin_b_i[0]
    && sel_q[9:8] == 2'h1 |-> ##[1:6] capture_pulse_o) else $error("no capture, b low");
  pin_high_a: assert property ($rose(timer_io_pin_a_i[1]) && timer_io_pin_b_i[1]
    && sel_q[11:10] == 2'h2 |-> ##[1:6] capture_pulse_o) else $error("no capture, b high");
  pin_any_a: assert property ($rose(timer_io_pin_a_i[3]) && sel_q[15:14] == 2'h3
    |-> ##[1:6] capture_pulse_o) else $error("no capture on any b level");
endmodule // cbs_props
bind cbs_capture_b cbs_props u_props (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .external_trigger_i(external_trigger_i),
  .timer_io_pin_a_i(timer_io_pin_a_i),
  .timer_io_pin_b_i(timer_io_pin_b_i),
  .capture_register_b_o(capture_register_b_o),
  .capture_pulse_o(capture_pulse_o)
);

// ### cbs_pins_model.sv
/* Far-side model driving the trigger inputs and the timer pin pairs.
   Assumes the caller sequences calls one after another. */
`timescale 1ns/10ps
module cbs_pins_model (
  input wire mclk_i,
  output logic [3:0] trig_o,
  output logic [3:0] pin_a_o,
  output logic [3:0] pin_b_o
);
  initial {trig_o, pin_a_o, pin_b_o} = 12'h000;
  // Levels are held eight clocks so the synchroniser never merges two edges.
  task put(input logic [3:0] t, input logic [3:0] a, input logic [3:0] b);
    @(posedge mclk_i);
    trig_o <= t;
    pin_a_o <= a;
    pin_b_o <= b;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule // cbs_pins_model

// ### tb_top.sv
/* Self-checking bench for the capture B source block.
   Assumes the block answers APB at once and captures a few clocks after an edge. */
`timescale 1ns/10ps
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0] pstrb_i = 4'hF;
  wire [31:0] prdata_o;
  wire [31:0] capture_register_b_o;
  wire pready_o;
  wire pslverr_o;
  wire capture_pulse_o;
  wire [3:0] external_trigger_i;
  wire [3:0] timer_io_pin_a_i;
  wire [3:0] timer_io_pin_b_i;
  int bad_count = 0;
  int checks_done = 0;
  int caps = 0;
  logic [31:0] rd;
  logic er;
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (capture_pulse_o === 1'b1)
      caps <= caps + 1;
  cbs_capture_b uut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .external_trigger_i(external_trigger_i),
    .timer_io_pin_a_i(timer_io_pin_a_i),
    .timer_io_pin_b_i(timer_io_pin_b_i),
    .capture_register_b_o(capture_register_b_o),
    .capture_pulse_o(capture_pulse_o)
  );
  cbs_pins_model u_pins (.mclk_i(mclk_i), .trig_o(external_trigger_i),
    .pin_a_o(timer_io_pin_a_i), .pin_b_o(timer_io_pin_b_i));
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge mclk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (i == 16)
    begin
      bad_count++;
      summarize;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h00000000, "select reset");
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000FFFF, "select mask");
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h00000000, "unmapped read data");
    check({31'h00000000, er}, 32'h00000001, "unmapped error");
  endtask
  task t_trig;
    int c;
    for (int n = 0; n < 4; n++)
      for (int m = 0; m < 4; m++)
      begin
        apb(1'b1, 12'h000, m << (2 * n));
        c = caps;
        u_pins.put(4'h1 << n, 4'h0, 4'h0);
        check(caps - c, (m == 1 || m == 3), "rise captures");
        u_pins.put(4'h0, 4'h0, 4'h0);
        check(caps - c, (m == 0) ? 0 : (m == 3) ? 2 : 1, "edge captures");
      end
  endtask
  task t_pin;
    int c;
    for (int n = 0; n < 4; n++)
      for (int m = 0; m < 4; m++)
        for (int b = 0; b < 2; b++)
        begin
          apb(1'b1, 12'h000, m << (8 + 2 * n));
          u_pins.put(4'h0, 4'h0, b << n);
          c = caps;
          u_pins.put(4'h0, 4'h1 << n, b << n);
          check(caps - c, m == 3 || m == 1 + b, "pin captures");
          u_pins.put(4'h0, 4'h0, 4'h0);
        end
  endtask
  task t_multi;
    int c;
    logic [31:0] t0;
    apb(1'b1, 12'h000, 32'h00000105);
    apb(1'b0, 12'h008, 32'h0);
    t0 = rd;
    c = caps;
    u_pins.put(4'h3, 4'h1, 4'h0);
    check(caps - c, 1, "merged captures");
    apb(1'b0, 12'h004, 32'h0);
    check(rd, t0 + 32'h00000005, "captured count");
    check(capture_register_b_o, t0 + 32'h00000005, "capture port");
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h00000001, "status seen");
    apb(1'b1, 12'h00C, 32'h00000001);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h00000000, "status cleared");
    u_pins.put(4'h0, 4'h0, 4'h0);
    u_pins.put(4'h1, 4'h0, 4'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h00000001, "status set again");
    u_pins.put(4'h0, 4'h0, 4'h0);
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs;
    t_trig;
    t_pin;
    t_multi;
    summarize;
  end
endmodule // tb_top
